// ===== rtl/sfp_core.sv
// Functional notes
// - Accept fast read opcode at any rate and slow read opcode at low rates.
// - Read address counter advances by itself after each output byte.
// - Read past the last array byte continues at address zero without gap.
// - Read data leave the serial output most significant bit first.
// - Chip select release ends a read at once and floats the output.
// - Program opcode, three address bytes, then data into the page buffer.
// - Program starts only with the write enable latch already set.
// - Program data past the page end wrap to the start of that page.
// - With more than a page sent, only the last 256 bytes stay.
// - On release, buffered bytes are programmed; unsent locations keep their contents.
// - Program aborts without change on short header, no data, or odd bits.
// - Program against a protected array is refused, back to idle.
// - Program aborts and protection refusals clear the write enable latch.
// - Program cycle shows busy and clears the latch before it ends.
// - Each programmed byte is read back; mismatch sets the error flag.
// - One opcode erases 4 Kbytes, two others erase 32 Kbytes, latch needed.
// - Erase takes three address bytes, ignores the rest, starts on release.
// - Erase ignores address bits below the block size.
// - Erase aborts without effect on short address or odd bit count.
// - Protected erase is refused; refusals and aborts clear the latch.
// - Erase shows busy, clears the latch, and reports failure in the flag.
// - The top eight address bits are disregarded.
// - Input sampled on rising clock, output changed on falling; modes 0 and 3.
// - Protect bit set means whole array protected for program and erase.
//
// Purpose: Read, page program and block erase command logic of a serial flash.
// Assumes: The SPI pins are oversampled by mclk; SCK half period over three mclk cycles.
// Notes: The array has a registered read port and accepts byte writes and erase requests.
`timescale 1ns/1ps
module sfp_core
	import sfp_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rstn,
	// Serial pins.
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// Status and protection.
	input wire logic block_protect_bit,
	input wire logic latch_set,
	input wire logic latch_clr,
	output logic write_enable_latch,
	output logic busy,
	output logic program_erase_error_flag,
	// Array port.
	output logic [ADDR_W-1:0] arr_rd_addr,
	input wire logic [7:0] arr_rd_data,
	output sfp_arr_wr_type arr_wr,
	output sfp_erase_type erase_req,
	input wire logic erase_done,
	input wire logic erase_fail
);

	logic [2:0] cs_sync_reg;
	logic [2:0] sck_sync_reg;
	logic [1:0] si_sync_reg;
	sfp_state_type state_reg;
	sfp_cmd_type cmd_reg;
	logic [2:0] bit_cnt_reg;
	logic [2:0] hdr_cnt_reg;
	logic [7:0] shin_reg;
	logic [15:0] addr_reg;
	logic [7:0] page_reg;
	logic [7:0] buf_ptr_reg;
	logic [PAGE_BYTES-1:0] valid_reg;
	logic data_seen_reg;
	logic fetch_q1_reg;
	logic fetch_q2_reg;
	logic [7:0] shout_reg;
	logic [7:0] idx_reg;
	logic [2:0] step_reg;
	logic [7:0] cmp_reg;
	logic [7:0] buf_rdata;
	logic so_reg;
	logic so_oe_reg;
	logic write_enable_latch_reg;
	logic busy_reg;
	logic program_erase_error_flag_reg;
	logic [ADDR_W-1:0] arr_rd_addr_reg;
	sfp_arr_wr_type arr_wr_reg;
	sfp_erase_type erase_req_reg;

	logic cs_low, cs_fall, cs_rise, sck_rise, sck_fall, si_bit;
	logic in_frame, byte_done, addr_last_byte, fetch, odd_end, is_erase;
	logic prog_ok, prog_abort, erase_ok, erase_abort, start_prog, start_erase;
	logic buf_we, chk_fail, prog_last, latch_drop;
	logic [7:0] byte_val;

	// Three flip-flops on cs_n and sck, two on si; only the second stage and later are looked at.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cs_sync_reg <= 3'h7;
			sck_sync_reg <= 3'h0;
			si_sync_reg <= 2'h0;
		end else begin
			cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
			sck_sync_reg <= {sck_sync_reg[1:0], sck};
			si_sync_reg <= {si_sync_reg[0], si};
		end
	end

	// Edge detection; the idle level of SCK does not matter, so modes 0 and 3 both work.
	// rising-edge sampling
	assign cs_low = !cs_sync_reg[1];
	assign cs_fall = cs_sync_reg[2] & !cs_sync_reg[1];
	assign cs_rise = !cs_sync_reg[2] & cs_sync_reg[1];
	assign sck_rise = !sck_sync_reg[2] & sck_sync_reg[1];
	assign sck_fall = sck_sync_reg[2] & !sck_sync_reg[1];
	assign si_bit = si_sync_reg[1];

	// Frame bookkeeping terms.
	assign in_frame = cs_low && (state_reg inside {ST_OPCODE, ST_ADDR, ST_DUMMY, ST_READ,
		ST_PDATA, ST_EHOLD, ST_IGNORE});
	assign byte_val = {shin_reg[6:0], si_bit};
	assign byte_done = in_frame && sck_rise && (bit_cnt_reg == BIT_LAST);
	assign addr_last_byte = byte_done && (state_reg == ST_ADDR) && (hdr_cnt_reg == HDR_ADDR_LAST);
	assign odd_end = bit_cnt_reg != BIT_FIRST;
	assign is_erase = (cmd_reg == CMD_ERASE_4K) || (cmd_reg == CMD_ERASE_32K);
	assign fetch = (addr_last_byte && (cmd_reg == CMD_READ_SLOW)) ||
		(byte_done && (state_reg == ST_DUMMY)) || (byte_done && (state_reg == ST_READ));

	// End-of-frame verdicts for program and erase.
	// program abort check
	assign prog_ok = (cmd_reg == CMD_PROG) && (state_reg == ST_PDATA) && data_seen_reg && !odd_end;
	assign prog_abort = (cmd_reg == CMD_PROG) && (state_reg inside {ST_ADDR, ST_PDATA}) &&
		(!prog_ok || block_protect_bit);
	assign erase_ok = is_erase && (state_reg == ST_EHOLD) && !odd_end;
	assign erase_abort = is_erase && (state_reg inside {ST_ADDR, ST_EHOLD}) &&
		(!erase_ok || block_protect_bit);
	assign start_prog = cs_rise && prog_ok && !block_protect_bit && write_enable_latch_reg;
	assign start_erase = cs_rise && erase_ok && !block_protect_bit && write_enable_latch_reg;
	assign latch_drop = cs_rise && (prog_abort || erase_abort);

	// Bit counter restarts on the chip select falling edge so a new frame starts on a byte.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			bit_cnt_reg <= BIT_FIRST;
			shin_reg <= 8'h00;
		end else if (cs_fall) begin
			bit_cnt_reg <= BIT_FIRST;
		end else if (in_frame && sck_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shin_reg <= byte_val;
		end
	end

	// Header byte count saturates once the address is complete.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			hdr_cnt_reg <= HDR_NONE;
		end else if (cs_fall) begin
			hdr_cnt_reg <= HDR_NONE;
		end else if (byte_done && (hdr_cnt_reg != HDR_SAT)) begin
			hdr_cnt_reg <= hdr_cnt_reg + 3'h1;
		end
	end

	// Opcode and address capture; a 16-bit shift drops the top address byte by itself.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cmd_reg <= CMD_NONE;
			addr_reg <= 16'h0000;
		end else if (byte_done && (state_reg == ST_OPCODE)) begin
			cmd_reg <= sfp_decode(byte_val);
		end else if (byte_done && (state_reg == ST_ADDR)) begin
			addr_reg <= {addr_reg[7:0], byte_val};
		end
	end

	// Command state machine.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (cs_fall) begin
						state_reg <= ST_OPCODE;
					end
				end
				ST_OPCODE, ST_ADDR, ST_DUMMY, ST_READ, ST_PDATA, ST_EHOLD, ST_IGNORE: begin
					if (cs_rise) begin
						if (start_erase) begin
							state_reg <= ST_ERASE;
						end else if (start_prog) begin
							state_reg <= ST_PROG;
						end else begin
							state_reg <= ST_IDLE;
						end
					end else if (byte_done && (state_reg == ST_OPCODE)) begin
						state_reg <= (sfp_decode(byte_val) == CMD_NONE) ? ST_IGNORE : ST_ADDR;
					end else if (addr_last_byte) begin
						case (cmd_reg)
							CMD_READ_FAST: state_reg <= ST_DUMMY;
							CMD_READ_SLOW: state_reg <= ST_READ;
							CMD_PROG: state_reg <= ST_PDATA;
							default: state_reg <= ST_EHOLD;
						endcase
					end else if (byte_done && (state_reg == ST_DUMMY)) begin
						state_reg <= ST_READ;
					end
				end
				ST_PROG: begin
					if (prog_last) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_ERASE: begin
					if (erase_done) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Page buffer filling; the pointer wraps inside the page, so old bytes get overwritten.
	// data into page buffer
	assign buf_we = byte_done && (state_reg == ST_PDATA);
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			page_reg <= 8'h00;
			buf_ptr_reg <= 8'h00;
			valid_reg <= '0;
			data_seen_reg <= 1'b0;
		end else if (addr_last_byte && (cmd_reg == CMD_PROG)) begin
			page_reg <= addr_reg[7:0];
			buf_ptr_reg <= byte_val;
			valid_reg <= '0;
			data_seen_reg <= 1'b0;
		end else if (buf_we) begin
			buf_ptr_reg <= buf_ptr_reg + 8'h01;
			valid_reg[buf_ptr_reg] <= 1'b1;
			data_seen_reg <= 1'b1;
		end
	end

	sfp_page_mem u_page_mem (
		.mclk(mclk),
		.we(buf_we),
		.waddr(buf_ptr_reg),
		.wdata(byte_val),
		.raddr(idx_reg),
		.rdata(buf_rdata)
	);

	// Read prefetch pipe: address register, array register, then the shifter.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			fetch_q1_reg <= 1'b0;
			fetch_q2_reg <= 1'b0;
		end else begin
			fetch_q1_reg <= fetch;
			fetch_q2_reg <= fetch_q1_reg;
		end
	end

	// One array read port serves both the read stream and program verify.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			arr_rd_addr_reg <= ADDR_FIRST;
		end else if (addr_last_byte) begin
			arr_rd_addr_reg <= {addr_reg[7:0], byte_val};
		end else if (fetch_q2_reg && (state_reg == ST_READ)) begin
			arr_rd_addr_reg <= arr_rd_addr_reg + 16'h0001;
		end else if ((state_reg == ST_PROG) && (step_reg == STEP_RD_ARR)) begin
			arr_rd_addr_reg <= {page_reg, idx_reg};
		end
	end

	// Output shifter; a fresh byte is loaded well before the next falling edge.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			shout_reg <= BYTE_ERASED;
			so_reg <= 1'b0;
		end else if (fetch_q2_reg && (state_reg == ST_READ)) begin
			shout_reg <= arr_rd_data;
		end else if (sck_fall && (state_reg == ST_READ)) begin
			so_reg <= shout_reg[7];
			shout_reg <= {shout_reg[6:0], 1'b0};
		end
	end

	// Output enable follows the read data phase and drops as soon as the frame ends.
	// float on release
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			so_oe_reg <= 1'b0;
		end else if (cs_rise || (state_reg != ST_READ)) begin
			so_oe_reg <= 1'b0;
		end else if (fetch_q2_reg) begin
			so_oe_reg <= 1'b1;
		end
	end

	// Program cycle: five steps per page location, unsent locations are stepped through but not written or checked.
	// readback compare
	assign chk_fail = (state_reg == ST_PROG) && (step_reg == STEP_CHECK) &&
		valid_reg[idx_reg] && (arr_rd_data != cmp_reg);
	assign prog_last = (state_reg == ST_PROG) && (step_reg == STEP_CHECK) && (idx_reg == PAGE_LAST);
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			idx_reg <= 8'h00;
			step_reg <= STEP_READ_BUF;
			cmp_reg <= BYTE_ERASED;
			arr_wr_reg <= '0;
		end else if (start_prog) begin
			idx_reg <= 8'h00;
			step_reg <= STEP_READ_BUF;
		end else if (state_reg == ST_PROG) begin
			case (step_reg)
				STEP_READ_BUF: step_reg <= STEP_WRITE;
				STEP_WRITE: begin
					cmp_reg <= buf_rdata;
					arr_wr_reg <= {valid_reg[idx_reg], {page_reg, idx_reg}, buf_rdata};
					step_reg <= STEP_RD_ARR;
				end
				STEP_RD_ARR: begin
					arr_wr_reg.en <= 1'b0;
					step_reg <= STEP_WAIT;
				end
				STEP_WAIT: step_reg <= STEP_CHECK;
				default: begin
					idx_reg <= idx_reg + 8'h01;
					step_reg <= STEP_READ_BUF;
				end
			endcase
		end
	end

	// Erase request with the low block bits forced to zero.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			erase_req_reg <= '0;
		end else if (start_erase) begin
			erase_req_reg.en <= 1'b1;
			erase_req_reg.big <= cmd_reg == CMD_ERASE_32K;
			erase_req_reg.addr <= addr_reg & ((cmd_reg == CMD_ERASE_32K) ? MASK_32K : MASK_4K);
		end else begin
			erase_req_reg.en <= 1'b0;
		end
	end

	// Busy covers the whole internal cycle; the latch drops at its very start.
	// busy and latch clear
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			busy_reg <= 1'b0;
		end else if (start_prog || start_erase) begin
			busy_reg <= 1'b1;
		end else if (prog_last || ((state_reg == ST_ERASE) && erase_done)) begin
			busy_reg <= 1'b0;
		end
	end

	// Write enable latch; a set from outside is not honoured while a cycle starts or runs.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			write_enable_latch_reg <= 1'b0;
		end else if (start_prog || start_erase) begin
			write_enable_latch_reg <= 1'b0;
		end else if (latch_set && !busy_reg) begin
			write_enable_latch_reg <= 1'b1;
		end else if (latch_drop || latch_clr) begin
			write_enable_latch_reg <= 1'b0;
		end
	end

	// Error flag is cleared when a new cycle starts and set by any failure.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			program_erase_error_flag_reg <= 1'b0;
		end else if (chk_fail || ((state_reg == ST_ERASE) && erase_done && erase_fail)) begin
			program_erase_error_flag_reg <= 1'b1;
		end else if (start_prog || start_erase) begin
			program_erase_error_flag_reg <= 1'b0;
		end
	end

	// Ports straight from the flip-flops.
	assign so = so_reg;
	assign so_oe = so_oe_reg;
	assign write_enable_latch = write_enable_latch_reg;
	assign busy = busy_reg;
	assign program_erase_error_flag = program_erase_error_flag_reg;
	assign arr_rd_addr = arr_rd_addr_reg;
	assign arr_wr = arr_wr_reg;
	assign erase_req = erase_req_reg;

	// Checks on the command logic.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_prog_release;
		cs_rise && (cmd_reg == CMD_PROG) && (state_reg == ST_PDATA);
	endsequence

	sequence s_read_shift;
		(state_reg == ST_READ) && sck_fall && !fetch_q2_reg;
	endsequence

	prog_odd_abort_a: assert property (s_prog_release ##0 odd_end |=> !busy_reg ##0 !write_enable_latch_reg)
		else $error("program with odd bit count was not aborted");
	prog_protect_a: assert property (s_prog_release ##0 block_protect_bit |=> (state_reg == ST_IDLE) && !busy_reg)
		else $error("protected program did not return to idle");
	prog_start_a: assert property (s_prog_release ##0 (prog_ok && !block_protect_bit && write_enable_latch_reg) |=> busy_reg && !write_enable_latch_reg)
		else $error("valid program did not start busy with latch cleared");
	so_release_a: assert property (cs_rise |=> !so_oe_reg)
		else $error("serial output still driven after release");
	msb_first_a: assert property (s_read_shift |=> so_reg == $past(shout_reg[7]))
		else $error("serial output bit is not the shifter msb");
	read_wrap_a: assert property (fetch_q2_reg && (state_reg == ST_READ) && (arr_rd_addr_reg == ADDR_LAST) |=> arr_rd_addr_reg == ADDR_FIRST)
		else $error("read address did not wrap to zero");
	erase_mask_a: assert property (erase_req_reg.en && erase_req_reg.big |-> (erase_req_reg.addr & ~MASK_32K) == ADDR_FIRST)
		else $error("large erase address not block aligned");
	page_wrap_a: assert property (arr_wr_reg.en |-> arr_wr_reg.addr[15:8] == page_reg)
		else $error("program write left its page");
	erase_err_a: assert property ((state_reg == ST_ERASE) && erase_done && erase_fail |=> program_erase_error_flag_reg && !busy_reg)
		else $error("erase failure not reported");
	erase_abort_a: assert property (cs_rise && is_erase && (state_reg == ST_ADDR) |=> !busy_reg && !write_enable_latch_reg)
		else $error("short erase header did not abort");
	verify_fail_a: assert property (chk_fail |=> program_erase_error_flag_reg)
		else $error("program mismatch not flagged");

endmodule

// ===== common/sfp_pkg.sv
// Purpose: Shared constants, states and carriers of the serial flash command block.
// Assumes: A 64-Kbyte array behind a registered read port, pages of 256 bytes.
// Notes: Opcode decode lives here so that every user classifies commands alike.
package sfp_pkg;

	// Array and page geometry.
	localparam int ADDR_W = 16;
	localparam int PAGE_W = 8;
	localparam int PAGE_BYTES = 256;
	localparam logic [15:0] ADDR_LAST = 16'hffff;
	localparam logic [15:0] ADDR_FIRST = 16'h0000;
	localparam logic [15:0] MASK_4K = 16'hf000;
	localparam logic [15:0] MASK_32K = 16'h8000;
	localparam logic [7:0] PAGE_LAST = 8'hff;
	localparam logic [7:0] BYTE_ERASED = 8'hff;

	// Opcodes recognised by this block.
	localparam logic [7:0] OP_READ_FAST = 8'h0b;
	localparam logic [7:0] OP_READ_SLOW = 8'h03;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_ERASE_32K_A = 8'h52;
	localparam logic [7:0] OP_ERASE_32K_B = 8'hd8;

	// Frame counting.
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] HDR_NONE = 3'h0;
	localparam logic [2:0] HDR_ADDR_LAST = 3'h3;
	localparam logic [2:0] HDR_SAT = 3'h4;

	// Steps of the internal program cycle for one page location.
	localparam logic [2:0] STEP_READ_BUF = 3'h0;
	localparam logic [2:0] STEP_WRITE = 3'h1;
	localparam logic [2:0] STEP_RD_ARR = 3'h2;
	localparam logic [2:0] STEP_WAIT = 3'h3;
	localparam logic [2:0] STEP_CHECK = 3'h4;

	// Decoded command kinds.
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_READ_FAST = 3'h1,
		CMD_READ_SLOW = 3'h2,
		CMD_PROG = 3'h3,
		CMD_ERASE_4K = 3'h4,
		CMD_ERASE_32K = 3'h5
	} sfp_cmd_type;

	// Controller states, one-hot.
	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_OPCODE = 10'h002,
		ST_ADDR = 10'h004,
		ST_DUMMY = 10'h008,
		ST_READ = 10'h010,
		ST_PDATA = 10'h020,
		ST_EHOLD = 10'h040,
		ST_IGNORE = 10'h080,
		ST_PROG = 10'h100,
		ST_ERASE = 10'h200
	} sfp_state_type;

	// Byte write towards the array.
	typedef struct packed {
		logic en;
		logic [15:0] addr;
		logic [7:0] data;
	} sfp_arr_wr_type;

	// Block erase request towards the array.
	typedef struct packed {
		logic en;
		logic big;
		logic [15:0] addr;
	} sfp_erase_type;

	// Classifies an opcode byte; unknown opcodes give CMD_NONE.
	function automatic sfp_cmd_type sfp_decode(input logic [7:0] op);
		sfp_cmd_type kind;
		kind = CMD_NONE;
		case (op)
			OP_READ_FAST: kind = CMD_READ_FAST;
			OP_READ_SLOW: kind = CMD_READ_SLOW;
			OP_PROG: kind = CMD_PROG;
			OP_ERASE_4K: kind = CMD_ERASE_4K;
			OP_ERASE_32K_A: kind = CMD_ERASE_32K;
			OP_ERASE_32K_B: kind = CMD_ERASE_32K;
			default: kind = CMD_NONE;
		endcase
		return kind;
	endfunction

endpackage

// ===== rtl/sfp_page_mem.sv
// Purpose: The 256-byte page buffer that collects program data.
// Assumes: One write and one read port on mclk.
// Notes: Read data come out of a register, one cycle after the address.
`timescale 1ns/1ps
module sfp_page_mem
	import sfp_pkg::*;
(
	// Clock.
	input wire logic mclk,
	// Write port.
	input wire logic we,
	input wire logic [PAGE_W-1:0] waddr,
	input wire logic [7:0] wdata,
	// Read port.
	input wire logic [PAGE_W-1:0] raddr,
	output logic [7:0] rdata
);

	logic [7:0] mem_reg [PAGE_BYTES];

	// Storage needs no reset; stale bytes are masked by the valid bits outside.
	always_ff @(posedge mclk) begin
		if (we) begin
			mem_reg[waddr] <= wdata;
		end
		rdata <= mem_reg[raddr];
	end

endmodule

// ===== tb/sfp_host.sv
// Purpose: SPI host model that frames commands for the flash block.
// Assumes: Mode 0 or 3 and a 125 ns link clock period.
// Notes: Edges sit an odd multiple of 0.25 ns off the mclk grid, so they never race the sampler.
`timescale 1ns/1ps
module sfp_host (
	// Clock used for phase only.
	input wire logic mclk,
	// Serial pins.
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	logic mode;

	// Deselected with the link clock standing still.
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		mode = 1'b0;
	end

	task automatic open(input logic m);
		@(posedge mclk);
		#1.25 mode = m;
		sck = m;
		#125 cs_n = 1'b0;
		#125;
	endtask

	task automatic put(input int n, input logic [7:0] b, output logic [7:0] r);
		r = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			sck = 1'b0;
			si = b[i];
			#62.5 sck = 1'b1;
			r = {r[6:0], so_oe ? so : 1'bx};
			#62.5;
		end
	endtask

	// The data line is inverted on release so a stale level never reads as data.
	task automatic close();
		sck = mode;
		#125 cs_n = 1'b1;
		si = ~si;
		#250;
	endtask
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench of the serial flash command block.
// Assumes: The array model lives here; the SPI host is sfp_host.
// Notes: A byte-array reference follows every command and is compared on reads.
`timescale 1ns/1ps
module tb
	import sfp_pkg::*;
;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic cs_n, sck, si, so, so_oe, latch, busy, pef;
	logic bp = 1'b0;
	logic ws = 1'b0;
	logic wc = 1'b0;
	logic ed = 1'b0;
	logic ef = 1'b0;
	logic efail = 1'b0;
	logic m_latch = 1'b0;
	logic m_pef = 1'b0;
	logic [15:0] ra;
	logic [7:0] rd;
	logic [7:0] mem [65536];
	logic [7:0] ref_m [65536];
	logic [7:0] dq [$];
	logic [7:0] ops [8] = '{8'h02, 8'h02, 8'h02, 8'h20, 8'h02, 8'hd8, 8'h02, 8'h20};
	int nas [8] = '{2, 3, 3, 2, 3, 3, 3, 3};
	int nds [8] = '{0, 1, 0, 0, 1, 0, 1, 0};
	int pbs [8] = '{0, 3, 0, 0, 0, 0, 0, 5};
	sfp_arr_wr_type aw;
	sfp_erase_type er;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;

	// Free-running 125 MHz clock.
	always #4 mclk = ~mclk;

	sfp_core u_sfp_core (.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si),
		.so(so), .so_oe(so_oe), .block_protect_bit(bp), .latch_set(ws), .latch_clr(wc),
		.write_enable_latch(latch), .busy(busy), .program_erase_error_flag(pef),
		.arr_rd_addr(ra), .arr_rd_data(rd), .arr_wr(aw), .erase_req(er),
		.erase_done(ed), .erase_fail(ef));
	sfp_host u_sfp_host (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
		.so_oe(so_oe));

	// Array: registered read; a write only clears bits, as real cells do.
	always @(posedge mclk) begin
		rd <= mem[ra];
		if (aw.en)
			mem[aw.addr] <= mem[aw.addr] & aw.data;
		if (er.en)
			fork
				wipe(er);
			join_none
	end

	// Erase from the address as given; a missing mask shows up as a bad block.
	task automatic wipe(input sfp_erase_type e);
		repeat (100) @(posedge mclk);
		for (int i = 0; i < (e.big ? 32768 : 4096); i++)
			mem[e.addr + 16'(i)] = 8'hff;
		ed <= 1'b1;
		ef <= efail;
		@(posedge mclk);
		ed <= 1'b0;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Latch set or cleared by a one-cycle pulse; protection changes alongside.
	task automatic wen(input logic s, input logic p);
		@(posedge mclk);
		ws <= s;
		wc <= !s;
		bp <= p;
		@(posedge mclk);
		ws <= 1'b0;
		wc <= 1'b0;
		m_latch = s;
	endtask

	task automatic hdr(input logic [7:0] op, input logic [23:0] a, input int na, input logic m);
		logic [7:0] r;
		u_sfp_host.open(m);
		u_sfp_host.put(8, op, r);
		for (int i = 0; i < na; i++)
			u_sfp_host.put(8, a[23 - 8 * i -: 8], r);
	endtask

	// Reads n bytes, then drops select three bits into the next byte.
	task automatic rdchk(input logic [7:0] op, input logic [23:0] a, input int n, input logic m);
		logic [7:0] r;
		hdr(op, a, 3, m);
		if (op == OP_READ_FAST)
			u_sfp_host.put(8, 8'($urandom), r);
		for (int i = 0; i < n; i++) begin
			u_sfp_host.put(8, 8'($urandom), r);
			chk(r, ref_m[a[15:0] + 16'(i)]);
		end
		u_sfp_host.put(3, 8'h00, r);
		u_sfp_host.close();
		chk({7'h00, so_oe}, 8'h00);
	endtask

	// Program or erase frame; the reference decides whether the array changes.
	task automatic run(input logic [7:0] op, input logic [23:0] a, input int na, input int nd,
		input int pb);
		logic [7:0] r;
		logic [15:0] b;
		logic ok;
		logic known;
		hdr(op, a, na, 1'b0);
		for (int i = 0; i < nd; i++)
			u_sfp_host.put(8, dq[i], r);
		if (pb > 0)
			u_sfp_host.put(pb, 8'h5a, r);
		u_sfp_host.close();
		// Unknown opcodes leave everything alone, the latch included.
		known = op inside {OP_PROG, OP_ERASE_4K, OP_ERASE_32K_A, OP_ERASE_32K_B};
		ok = known && na == 3 && pb == 0 && !bp && (op != OP_PROG || nd > 0);
		b = a[15:0];
		if (ok && m_latch) begin
			m_pef = efail && op != OP_PROG;
			if (op == OP_PROG) begin
				for (int i = (nd > 256 ? nd - 256 : 0); i < nd; i++) begin
					b[7:0] = a[7:0] + 8'(i);
					if ((ref_m[b] & dq[i]) !== dq[i])
						m_pef = 1'b1;
					ref_m[b] = ref_m[b] & dq[i];
				end
			end else begin
				b = b & (op == OP_ERASE_4K ? MASK_4K : MASK_32K);
				for (int i = 0; i < (op == OP_ERASE_4K ? 4096 : 32768); i++)
					ref_m[b + 16'(i)] = 8'hff;
			end
		end
		chk({7'h00, busy}, {7'h00, ok && m_latch});
		if (known)
			m_latch = 1'b0;
		// Polled on the falling edge, away from the edge that updates the flags.
		for (int i = 0; i < 3000 && busy !== 1'b0; i++)
			@(negedge mclk);
		chk({5'h00, busy, latch, pef}, {6'h00, m_latch, m_pef});
	endtask

	// Watchdog well above the expected run of about 50000 cycles.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			fails++;
			end_of_test();
		end
	end

	// Main sequence.
	initial begin
		void'($urandom(31));
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'($urandom);
			ref_m[i] = mem[i];
		end
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		repeat (4) @(posedge mclk);
		chk({4'h0, so_oe, latch, busy, pef}, 8'h00);
		rdchk(OP_READ_FAST, 24'h7bfffd, 5, 1'b1);
		rdchk(OP_READ_SLOW, 24'($urandom), 3, 1'b0);
		wen(1'b1, 1'b0);
		run(OP_ERASE_32K_A, {8'($urandom), 16'h89ab}, 3, 0, 0);
		efail = 1'b1;
		wen(1'b1, 1'b0);
		run(OP_ERASE_32K_B, 24'h7f4321, 3, 0, 0);
		efail = 1'b0;
		dq = {8'h00, 8'h5a, 8'hc3};
		wen(1'b1, 1'b0);
		run(OP_PROG, 24'h3312fe, 3, 3, 0);
		rdchk(OP_READ_SLOW, 24'h0012fc, 4, 1'b0);
		rdchk(OP_READ_SLOW, 24'h001200, 2, 1'b0);
		dq = {};
		for (int i = 0; i < 257; i++)
			dq.push_back(8'($urandom));
		wen(1'b1, 1'b0);
		run(OP_PROG, 24'h0045fe, 3, 257, 0);
		rdchk(OP_READ_FAST, 24'h0045fc, 6, 1'b0);
		dq = {8'h11, 8'h22};
		wen(1'b1, 1'b0);
		run(OP_ERASE_4K, 24'h004abc, 3, 2, 0);
		rdchk(OP_READ_SLOW, 24'h0045fe, 2, 1'b0);
		rdchk(OP_READ_SLOW, 24'h0012fe, 3, 1'b0);
		dq = {8'hff};
		wen(1'b1, 1'b0);
		run(OP_PROG, 24'h0012fe, 3, 1, 0);
		dq = {8'h00};
		for (int k = 0; k < 8; k++) begin
			wen(k != 4, k == 5 || k == 6);
			run(ops[k], 24'h0012ff, nas[k], nds[k], pbs[k]);
		end
		wen(1'b1, 1'b0);
		run(8'h77, 24'h0012ff, 3, 1, 0);
		rdchk(OP_READ_SLOW, 24'h0012fe, 3, 1'b1);
		end_of_test();
	end
endmodule
